// ===== dv/dks_exec_props.sv
// Purpose: Checks the decrement-and-skip block at its ports.
// Assumes: Bound to dks_exec.
// Notes: Address checks hold for any word, valid or not.
`timescale 1ns/10ps
module dks_exec_props (
   input wire logic        i_clock,
   input wire logic        i_arst_n,
   input wire logic        i_instr_valid,
   input wire logic        i_next_two_word,
   input wire logic        i_extended_en,
   input wire logic [15:0] i_instr,
   input wire logic [3:0]  i_bank_select_register,
   input wire logic [11:0] i_index_base,
   input wire logic [11:0] o_file_raddr,
   input wire logic [11:0] o_file_waddr,
   input wire logic [7:0]  i_file_rdata,
   input wire logic [7:0]  o_file_wdata,
   input wire logic [7:0]  o_wreg,
   input wire logic        o_file_we,
   input wire logic        o_skip,
   input wire logic        o_flush,
   input wire logic        o_indexed,
   input wire logic        o_status_we
);
   wire logic [5:0] op  = i_instr[15:10];
   wire logic       rec = op == 6'h0B || op == 6'h13;
   wire logic       go  = i_instr_valid && !o_flush && rec;
   wire logic [7:0] res = i_file_rdata - 8'h01;
   wire logic       ix  = !i_instr[8] && i_extended_en && i_instr[7:0] <= 8'h5F;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);
   a_status_untouched: assert property (!o_status_we)
      else $error("status write seen");
   a_wreg_result: assert property (
      go && !i_instr[9] |=> !o_file_we && o_wreg == $past(res))
      else $error("accumulator result wrong");
   a_file_write: assert property (
      go && i_instr[9] |=> o_file_we && o_file_wdata == $past(res)
      && o_file_waddr == $past(o_file_raddr)) else $error("file write wrong");
   a_skip_zero: assert property (go && op == 6'h0B |=> o_skip == ($past(res) == 8'h00))
      else $error("zero skip wrong");
   a_skip_nonzero: assert property (go && op == 6'h13 |=> o_skip == ($past(res) != 8'h00))
      else $error("nonzero skip wrong");
   a_flush_single: assert property (o_skip && !$past(i_next_two_word) |-> o_flush ##1 !o_flush)
      else $error("single flush wrong");
   a_flush_double: assert property (o_skip && $past(i_next_two_word) |-> o_flush [*2] ##1 !o_flush)
      else $error("double flush wrong");
   a_access_bank: assert property (
      !i_instr[8] && !ix |-> o_file_raddr == {i_instr[7] ? 4'hF : 4'h0, i_instr[7:0]})
      else $error("access bank address wrong");
   a_bank_select: assert property (
      i_instr[8] |-> o_file_raddr == {i_bank_select_register, i_instr[7:0]})
      else $error("bank address wrong");
   a_indexed_addr: assert property (
      ix |-> o_file_raddr == 12'(i_index_base + {4'h0, i_instr[7:0]}))
      else $error("indexed address wrong");
   a_unknown_word: assert property (i_instr_valid && !rec |=> !o_file_we && !o_skip)
      else $error("unknown word acted on");
endmodule

// ===== dv/testbench.sv
// Purpose: Self-checking bench for the decrement-and-skip block.
// Assumes: One instruction per call, flush cycles waited out.
// Notes: None.
`timescale 1ns/10ps
module testbench import dks_pkg::*; ;
   logic        i_clock, i_arst_n, i_instr_valid, i_next_two_word, i_extended_en;
   logic [15:0] i_instr;
   logic [3:0]  i_bank_select_register;
   logic [11:0] i_index_base, o_file_raddr, o_file_waddr;
   logic [7:0]  i_file_rdata, o_file_wdata, o_wreg;
   logic        o_file_we, o_skip, o_flush, o_indexed, o_status_we;
   int          err_count, comparisons, cycles;
   dks_exec u_dut (.*);
   always #12.5 i_clock = ~i_clock;
   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (cycles == 500) begin
         err_count++;
         conclude();
      end
   end
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task conclude;
      if (err_count == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic op(input logic [15:0] w, input logic [7:0] rd, input logic tw,
                     input logic [11:0] ea, input logic [7:0] ed, input logic ew, es);
      @(posedge i_clock);
      i_instr <= w;
      i_instr_valid <= 1'b1;
      i_file_rdata <= rd;
      i_next_two_word <= tw;
      #1 chk("raddr", o_file_raddr, ea);
      @(posedge i_clock);
      i_instr_valid <= 1'b0;
      i_next_two_word <= 1'b0;
      #1 chk("we", o_file_we, ew);
      if (ew) chk("waddr", o_file_waddr, ea);
      chk("skip", o_skip, es);
      chk("flush", o_flush, es);
      chk("status", o_status_we, 0);
      chk("result", w[9] ? o_file_wdata : o_wreg, ed);
      if (es) begin
         @(posedge i_clock);
         #1 chk("flush2", o_flush, tw);
      end
   endtask
   initial begin
      i_clock = 0; i_arst_n = 0; i_instr_valid = 0; i_next_two_word = 0;
      i_extended_en = 0; i_instr = 16'h0000; i_bank_select_register = 4'h3;
      i_index_base = 12'h100; i_file_rdata = 8'h00;
      repeat (2) @(posedge i_clock);
      i_arst_n <= 1'b1;
      op(16'h2E10, 8'h01, 0, 12'h010, 8'h00, 1, 1);
      op(16'h2D20, 8'h05, 0, 12'h320, 8'h04, 0, 0);
      op(16'h4F44, 8'h00, 1, 12'h344, 8'hFF, 1, 1);
      op(16'h4C90, 8'h01, 0, 12'hF90, 8'h00, 0, 0);
      chk("not indexed", o_indexed, 0);
      i_extended_en <= 1'b1;
      op(16'h2E5F, 8'h80, 0, 12'h15F, 8'h7F, 1, 0);
      chk("indexed", o_indexed, 1);
      op(16'hFFFF, 8'h00, 0, 12'h3FF, 8'h7F, 0, 0);
      conclude();
   end
endmodule
bind dks_exec dks_exec_props u_props (.*);

// ===== inc/dks_map.svh
// Purpose: Constants for the decrement-and-skip execution block.
// Assumes: 16-bit instruction words, 8-bit data.
// Notes: Field positions refer to the instruction word.
`ifndef DKS_MAP_SVH
`define DKS_MAP_SVH
`define DKS_OP_MSB        15
`define DKS_OP_LSB        10
`define DKS_OP_DEC_SKZ    6'h0B
`define DKS_OP_DEC_SKNZ   6'h13
`define DKS_DEST_BIT      9
`define DKS_ACCESS_BIT    8
`define DKS_ADDR_MSB      7
`define DKS_INDEX_LIMIT   8'h5F
`define DKS_ACCESS_SPLIT  8'h80
`define DKS_SFR_BANK      4'hF
`define DKS_NOP_WORD      16'h0000
`define DKS_W_RESET       8'h00
`define DKS_ADDR_WIDTH    12
`endif

// ===== inc/dks_pkg.sv
// Purpose: Types for the decrement-and-skip execution block.
// Assumes: Constants come from dks_map.svh.
// Notes: None.
package dks_pkg;
   typedef enum logic [1:0] {
      DKS_EXEC  = 2'b00,
      DKS_FLUSH = 2'b01,
      DKS_FLUSH2 = 2'b10
   } dks_phase_t;

   typedef struct packed {
      logic        write_en;
      logic [11:0] addr;
      logic [7:0]  data;
   } dks_fwrite_t;

   typedef struct packed {
      dks_phase_t  phase;
      logic [7:0]  wreg;
      dks_fwrite_t fwr;
      logic        skip;
      logic        indexed;
      logic        busy;
   } dks_state_t;
endpackage

// ===== verilog/dks_exec.sv
// Purpose: Executes decrement-and-skip-if-zero and decrement-and-skip-if-nonzero.
// Assumes: One instruction word per i_clock cycle on i_instr with i_instr_valid.
// Notes: File read is combinational through i_file_rdata for o_file_raddr.
`timescale 1ns/10ps
`include "dks_map.svh"
module dks_exec
   import dks_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_arst_n,
   input  wire logic        i_instr_valid,
   input  wire logic [15:0] i_instr,
   input  wire logic        i_next_two_word,
   input  wire logic        i_extended_en,
   input  wire logic [3:0]  i_bank_select_register,
   input  wire logic [11:0] i_index_base,
   input  wire logic [7:0]  i_file_rdata,
   output logic      [11:0] o_file_raddr,
   output logic             o_file_we,
   output logic      [11:0] o_file_waddr,
   output logic      [7:0]  o_file_wdata,
   output logic      [7:0]  o_wreg,
   output logic             o_skip,
   output logic             o_flush,
   output logic             o_indexed,
   output logic             o_status_we
);

   dks_state_t st;
   dks_state_t next_st;

   // Resolves the full file address from access bit, bank and index mode.
   function automatic logic [12:0] resolve(input logic [15:0] w, input logic ext,
                                           input logic [3:0] bank,
                                           input logic [11:0] base);
      logic [7:0]  f;
      logic [11:0] a;
      logic        idx;
      f   = w[`DKS_ADDR_MSB:0];
      idx = 1'b0;
      if (w[`DKS_ACCESS_BIT]) begin
         a = {bank, f};
      end else if (ext && (f <= `DKS_INDEX_LIMIT)) begin
         a   = 12'(base + {4'h0, f});
         idx = 1'b1;
      end else if (f < `DKS_ACCESS_SPLIT) begin
         a = {4'h0, f};
      end else begin
         a = {`DKS_SFR_BANK, f};
      end
      return {idx, a};
   endfunction

   logic [5:0]  opcode;
   logic        is_skz;
   logic        is_sknz;
   logic        is_ours;
   logic [12:0] res_addr;
   logic [7:0]  result;
   logic        take_skip;

   always_comb begin
      opcode    = i_instr[`DKS_OP_MSB:`DKS_OP_LSB];
      is_skz    = (opcode == `DKS_OP_DEC_SKZ);
      is_sknz   = (opcode == `DKS_OP_DEC_SKNZ);
      is_ours   = i_instr_valid && (st.phase == DKS_EXEC) && (is_skz || is_sknz);
      res_addr  = resolve(i_instr, i_extended_en, i_bank_select_register, i_index_base);
      result    = 8'(i_file_rdata - 8'h01);
      take_skip = (is_skz && (result == 8'h00)) || (is_sknz && (result != 8'h00));
   end

   always_comb begin
      next_st              = st;
      next_st.fwr.write_en = 1'b0;
      next_st.skip         = 1'b0;
      next_st.busy         = 1'b0;
      unique case (st.phase)
         DKS_EXEC: begin
            if (is_ours) begin
               next_st.indexed = res_addr[12];
               if (i_instr[`DKS_DEST_BIT]) begin
                  next_st.fwr.write_en = 1'b1;
                  next_st.fwr.addr     = res_addr[11:0];
                  next_st.fwr.data     = result;
               end else begin
                  next_st.wreg = result;
               end
               if (take_skip) begin
                  next_st.skip  = 1'b1;
                  next_st.busy  = 1'b1;
                  // A two-word follower costs one more flushed cycle.
                  next_st.phase = i_next_two_word ? DKS_FLUSH2 : DKS_FLUSH;
               end
            end
         end
         DKS_FLUSH2: begin
            next_st.busy  = 1'b1;
            next_st.phase = DKS_FLUSH;
         end
         DKS_FLUSH: begin
            next_st.phase = DKS_EXEC;
         end
         default: begin
            next_st.phase = DKS_EXEC;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st.phase        <= DKS_EXEC;
         st.wreg         <= `DKS_W_RESET;
         st.fwr.write_en <= 1'b0;
         st.fwr.addr     <= 12'h000;
         st.fwr.data     <= 8'h00;
         st.skip         <= 1'b0;
         st.indexed      <= 1'b0;
         st.busy         <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign o_file_raddr = res_addr[11:0];
   assign o_file_we    = st.fwr.write_en;
   assign o_file_waddr = st.fwr.addr;
   assign o_file_wdata = st.fwr.data;
   assign o_wreg       = st.wreg;
   assign o_skip       = st.skip;
   // Flush stays high while a no-operation occupies the execute slot.
   assign o_flush      = (st.phase != DKS_EXEC);
   assign o_indexed    = st.indexed;
   assign o_status_we  = 1'b0;

endmodule
